/* File: rtl/pulse_counter_bank.sv */
// bank of 26 up/down 32-bit pulse counters on eight fast inputs,
// with an APB slave for control, direction monitors and count access.
// assumes the fast inputs are asynchronous pins and the APB master
// runs on sys_clk_i.
//
// Behaviour
// RQ1 - each counter holds a 32-bit up/down count
// RQ2 - counts follow input edges every clock, no scan
// RQ3 - single input counts on rising pulse edge only
// RQ4 - direction bit on counts down, off counts up
// RQ5 - up/down pins step count; monitor off=up, on=down
// RQ6 - quadrature single rate: once per cycle, phase direction
// RQ7 - fourfold mode keeps same direction monitor update
// RQ8 - fourfold counts all edges of both phases
// RQ9 - fourfold bit sharing: 0,2 and 1,3,4
// RQ10 - only four counters may use hardware mode
// RQ11 - source keeps single-phase hardware rate under 50kHz
// RQ12 - source keeps quadrature hardware rate under 30kHz
// RQ13 - summed hardware input rate stays under 80kHz
// RQ14 - compare-referenced counters fall back to software mode
// RQ15 - software mode: 10kHz single, 5kHz quadrature
// RQ16 - zone compare: 5kHz single, 4kHz quadrature
// RQ17 - software summed rate 80, 30 or 20kHz
// RQ18 - each fast input serves only one function (not enforced: every enabled counter wired to a pin uses it at once)
// RQ19 - reset pin clears count; start pin gates counting
// RQ20 - inputs synchronised and edge detected before counting
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module pulse_counter_bank
	import pulse_counter_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] fast_input_points_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);

	// ==========================================================
	// input synchroniser and edge history
	logic [7:0] pin_s1_q;
	logic [7:0] pin_s2_q;
	logic [7:0] pin_prev_q;
	logic [7:0] pin_s1_d;
	logic [7:0] pin_s2_d;
	logic [7:0] pin_prev_d;

	// two stages against metastability, a third for edge detection;
	// only the second stage reads the first, so no logic sees a metastable bit
	always_comb
	begin
		pin_s1_d = fast_input_points_i; // RQ20
		pin_s2_d = pin_s1_q; // RQ20
		pin_prev_d = pin_s2_q; // RQ20
	end

	// synchroniser registers, cleared to the idle pin level
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pin_s1_q <= 8'h00;
			pin_s2_q <= 8'h00;
			pin_prev_q <= 8'h00;
		end
		else
		begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
			pin_prev_q <= pin_prev_d;
		end
	end

	// pick one pin; a missing pin reads as low
	function automatic logic pin_at(input logic [7:0] v, input logic [3:0] code);
		if (code == PIN_NONE)
			return 1'b0;
		return v[code[2:0]];
	endfunction

	// ==========================================================
	// apb slave state
	logic [25:0] enable_q;
	logic [25:0] enable_d;
	logic [11:0] dir_sel_q;
	logic [11:0] dir_sel_d;
	logic [4:0] fourfold_q;
	logic [4:0] fourfold_d;
	logic [25:0] sw_ref_q;
	logic [25:0] sw_ref_d;
	logic [31:0] prdata_d;
	logic pready_d;
	logic pslverr_d;
	logic [25:0] hw_mode;
	logic cnt_hit;
	logic [11:0] cnt_off;
	logic [4:0] cnt_idx;
	logic wr_go;
	logic [31:0] rd_val;
	logic rd_err;
	logic cnt_ok;

	// a referenced counter loses hardware mode even if capable
	assign hw_mode = enable_q & HW_CAPABLE & ~sw_ref_q; // RQ10 RQ14
	assign cnt_hit = (paddr_i >= OFS_COUNT_BASE) && (paddr_i < OFS_COUNT_END);
	assign cnt_off = paddr_i - OFS_COUNT_BASE;
	assign cnt_idx = cnt_off[6:2];
	// unaligned count places are refused and must never load a count
	assign cnt_ok = cnt_hit && (paddr_i[1:0] == 2'h0);
	// writes land only on the edge where the master sees pready high
	assign wr_go = psel_i && penable_i && pready_o && pwrite_i;

	// ==========================================================
	// counter state
	logic [31:0] cnt_q [NUM_CNT];
	logic [31:0] cnt_d [NUM_CNT];
	logic [13:0] mon_q;
	logic [13:0] mon_d;
	logic a_now;
	logic a_old;
	logic b_now;
	logic b_old;
	logic up;
	logic dn;
	logic x4;
	logic run;
	logic clr;

	// read mux, answers zero with an error on unmapped words
	always_comb
	begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		case (paddr_i)
			OFS_ENABLE: rd_val = {6'h00, enable_q};
			OFS_DIR_SEL: rd_val = {20'h00000, dir_sel_q};
			OFS_FOURFOLD: rd_val = {27'h0000000, fourfold_q};
			OFS_SW_REF: rd_val = {6'h00, sw_ref_q};
			OFS_DIR_MON: rd_val = {18'h00000, mon_q};
			OFS_HW_MODE: rd_val = {6'h00, hw_mode};
			OFS_PINS: rd_val = {24'h000000, pin_s2_q};
			default:
			begin
				if (cnt_ok)
					rd_val = cnt_q[cnt_idx];
				else
					rd_err = 1'b1;
			end
		endcase
	end

	// next state of the bus side; one wait state before pready
	always_comb
	begin
		enable_d = enable_q;
		dir_sel_d = dir_sel_q;
		fourfold_d = fourfold_q;
		sw_ref_d = sw_ref_q;
		pready_d = psel_i && penable_i && !pready_o;
		prdata_d = prdata_o;
		pslverr_d = 1'b0;
		if (psel_i && penable_i && !pready_o)
		begin
			prdata_d = pwrite_i ? 32'h00000000 : rd_val;
			pslverr_d = rd_err;
		end
		if (wr_go)
		begin
			case (paddr_i)
				OFS_ENABLE: enable_d = pwdata_i[25:0];
				OFS_DIR_SEL: dir_sel_d = pwdata_i[11:0]; // RQ4
				OFS_FOURFOLD: fourfold_d = pwdata_i[4:0]; // RQ9
				OFS_SW_REF: sw_ref_d = pwdata_i[25:0]; // RQ14
				default: enable_d = enable_q;
			endcase
		end
	end

	// bus side registers
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			enable_q <= RST_ENABLE;
			dir_sel_q <= RST_DIR_SEL;
			fourfold_q <= RST_FOURFOLD;
			sw_ref_q <= RST_SW_REF;
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			enable_q <= enable_d;
			dir_sel_q <= dir_sel_d;
			fourfold_q <= fourfold_d;
			sw_ref_q <= sw_ref_d;
			prdata_o <= prdata_d;
			pready_o <= pready_d;
			pslverr_o <= pslverr_d;
		end
	end

	// ==========================================================
	// counting: every clock, independent of software polling
	// priority is reset pin, then a bus load, then a count step
	always_comb
	begin
		a_now = 1'b0;
		a_old = 1'b0;
		b_now = 1'b0;
		b_old = 1'b0;
		up = 1'b0;
		dn = 1'b0;
		x4 = 1'b0;
		run = 1'b0;
		clr = 1'b0;
		mon_d = mon_q;
		for (int i = 0; i < NUM_CNT; i++)
		begin
			cnt_d[i] = cnt_q[i];
			a_now = pin_at(pin_s2_q, CNT_PIN_A[i]);
			a_old = pin_at(pin_prev_q, CNT_PIN_A[i]);
			b_now = pin_at(pin_s2_q, CNT_PIN_B[i]);
			b_old = pin_at(pin_prev_q, CNT_PIN_B[i]);
			up = 1'b0;
			dn = 1'b0;
			x4 = 1'b0;
			if (i < FIRST_UD)
			begin
				// single input: rising edge only, direction from its bit
				up = a_now && !a_old && !dir_sel_q[(i < NUM_SGL) ? i : 0]; // RQ3 RQ4
				dn = a_now && !a_old && dir_sel_q[(i < NUM_SGL) ? i : 0]; // RQ3 RQ4
			end
			else if (i < FIRST_QD)
			begin
				// simultaneous up and down edges cancel out
				up = a_now && !a_old && !(b_now && !b_old); // RQ5
				dn = b_now && !b_old && !(a_now && !a_old); // RQ5
			end
			else
			begin
				x4 = fourfold_q[QD_FF_SEL[(i >= FIRST_QD) ? i - FIRST_QD : 0]]; // RQ9
				if (x4)
				begin
					// a change on both phases at once is ambiguous, dropped
					if ((a_now != a_old) && (b_now == b_old))
					begin
						up = (a_now != b_now); // RQ8
						dn = (a_now == b_now); // RQ8
					end
					else if ((b_now != b_old) && (a_now == a_old))
					begin
						up = (a_now == b_now); // RQ8
						dn = (a_now != b_now); // RQ8
					end
				end
				else
				begin
					// phase a leading means b still low at a's rise
					up = a_now && !a_old && !b_now; // RQ6
					dn = a_now && !a_old && b_now; // RQ6
				end
			end
			run = enable_q[i] && ((CNT_PIN_START[i] == PIN_NONE)
				|| pin_at(pin_s2_q, CNT_PIN_START[i])); // RQ19
			clr = pin_at(pin_s2_q, CNT_PIN_RST[i]); // RQ19
			if (clr)
				cnt_d[i] = RST_COUNT; // RQ19
			else if (wr_go && cnt_ok && (cnt_idx == i[4:0]))
				cnt_d[i] = pwdata_i;
			else if (run && up)
				cnt_d[i] = cnt_q[i] + 32'h00000001; // RQ1 RQ2
			else if (run && dn)
				cnt_d[i] = cnt_q[i] - 32'h00000001; // RQ1 RQ2
			// monitor follows the last direction seen while running, even when the reset pin or a bus load wins
			if ((i >= FIRST_UD) && run && (up || dn))
				mon_d[(i >= FIRST_UD) ? i - FIRST_UD : 0] = dn; // RQ5 RQ6 RQ7
		end
	end

	// counter registers
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mon_q <= RST_DIR_MON;
			for (int i = 0; i < NUM_CNT; i++)
				cnt_q[i] <= RST_COUNT;
		end
		else
		begin
			mon_q <= mon_d;
			for (int i = 0; i < NUM_CNT; i++)
				cnt_q[i] <= cnt_d[i];
		end
	end

endmodule

/* File: rtl/pulse_counter_pkg.sv */
// constants for the high-speed pulse counter bank: sizes, register map,
// reset values and the fixed wiring of each counter to the fast inputs.
// assumes a 32-bit APB slave with 12 address bits decoded.
package pulse_counter_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_PINS = 8;
	localparam int NUM_CNT = 26;
	localparam int NUM_SGL = 12;
	localparam int FIRST_UD = 12;
	localparam int FIRST_QD = 18;
	localparam int NUM_MON = 14;
	localparam int NUM_QD = 8;
	localparam int CNT_W = 32;
	localparam int ADDR_W = 12;
	localparam logic [3:0] PIN_NONE = 4'hF;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [11:0] OFS_ENABLE = 12'h000;
	localparam logic [11:0] OFS_DIR_SEL = 12'h004;
	localparam logic [11:0] OFS_FOURFOLD = 12'h008;
	localparam logic [11:0] OFS_SW_REF = 12'h00C;
	localparam logic [11:0] OFS_DIR_MON = 12'h010;
	localparam logic [11:0] OFS_HW_MODE = 12'h014;
	localparam logic [11:0] OFS_PINS = 12'h018;
	localparam logic [11:0] OFS_COUNT_BASE = 12'h040;
	localparam logic [11:0] OFS_COUNT_END = 12'h0A8;

	// ==========================================================
	// reset values
	localparam logic [25:0] RST_ENABLE = 26'h0000000;
	localparam logic [11:0] RST_DIR_SEL = 12'h000;
	localparam logic [4:0] RST_FOURFOLD = 5'h00;
	localparam logic [25:0] RST_SW_REF = 26'h0000000;
	localparam logic [13:0] RST_DIR_MON = 14'h0000;
	localparam logic [31:0] RST_COUNT = 32'h00000000;

	// counters able to run in hardware mode: indices 0, 1, 12, 18
	localparam logic [25:0] HW_CAPABLE = 26'h0041003;

	// ==========================================================
	// wiring: index 0..11 single input, 12..17 up/down, 18..25 quadrature
	// pin a is the pulse, up or phase a input; pin b is down or phase b
	localparam logic [3:0] CNT_PIN_A [NUM_CNT] = '{
		4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h0, 4'h3, 4'h0, 4'h3, 4'h6, 4'h7,
		4'h0, 4'h0, 4'h3, 4'h0, 4'h3, 4'h3,
		4'h0, 4'h0, 4'h3, 4'h0, 4'h3, 4'h2, 4'h4, 4'h6};
	localparam logic [3:0] CNT_PIN_B [NUM_CNT] = '{
		4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF,
		4'h1, 4'h1, 4'h4, 4'h1, 4'h4, 4'h4,
		4'h1, 4'h1, 4'h4, 4'h1, 4'h4, 4'h3, 4'h5, 4'h7};
	localparam logic [3:0] CNT_PIN_RST [NUM_CNT] = '{
		4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h2, 4'h5, 4'h2, 4'h5, 4'hF, 4'hF,
		4'hF, 4'h2, 4'h5, 4'h2, 4'h5, 4'hF,
		4'hF, 4'h2, 4'h5, 4'h2, 4'h5, 4'hF, 4'hF, 4'hF};
	localparam logic [3:0] CNT_PIN_START [NUM_CNT] = '{
		4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h6, 4'h7, 4'hF, 4'hF,
		4'hF, 4'hF, 4'hF, 4'h6, 4'h7, 4'hF,
		4'hF, 4'hF, 4'hF, 4'h6, 4'h7, 4'hF, 4'hF, 4'hF};
	// fourfold-select bit used by each quadrature counter
	localparam logic [2:0] QD_FF_SEL [NUM_QD] = '{
		3'h0, 3'h0, 3'h2, 3'h0, 3'h2, 3'h1, 3'h3, 3'h4};
endpackage

/* File: test/pulse_counter_monitor.sv */
// checker for the pulse counter bank, watching only its top ports.
// assumes the master holds each request until pready_o is sampled.
`timescale 1ns/1ps
module pulse_counter_monitor
	import pulse_counter_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] fast_input_points_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// address classes; unaligned places are left unchecked on purpose
	logic hole;
	logic mapped;
	logic rd_done;
	assign hole = paddr_i[1:0] == 2'h0 && ((paddr_i > OFS_PINS && paddr_i < OFS_COUNT_BASE)
		|| paddr_i >= OFS_COUNT_END);
	assign mapped = paddr_i[1:0] == 2'h0 && !hole;
	assign rd_done = pready_o && !pwrite_i && !pslverr_o;
	sequence s_first;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence s_answer;
		pready_o && psel_i && penable_i;
	endsequence
	// ==========================================================
	// bus timing and refusals
	a_one_wait: assert property (s_first |=> s_answer)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	a_hole_err: assert property ((psel_i && penable_i && !pready_o && hole) |=> pslverr_o)
		else $error("unmapped access not refused");
	a_map_no_err: assert property ((psel_i && penable_i && !pready_o && mapped) |=> !pslverr_o)
		else $error("mapped access refused");
	a_err_rd_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h00000000)
		else $error("refused read returned data");
	// a write answer clears the read data, so data moves only at an answer
	a_rdata_hold: assert property (!$stable(prdata_o) |-> pready_o)
		else $error("read data moved outside an answer");
	a_wr_rdata_zero: assert property (pready_o && pwrite_i |-> prdata_o == 32'h00000000)
		else $error("write answer carried read data");
	// pin levels are read back after two synchroniser stages
	a_pin_sync: assert property (
		rd_done && paddr_i == OFS_PINS && $past(fast_input_points_i, 2) == $past(fast_input_points_i, 3)
		&& $past(fast_input_points_i, 3) == $past(fast_input_points_i, 4)
		|-> prdata_o == {24'h000000, $past(fast_input_points_i, 3)})
		else $error("pin level read back wrong");
	a_hw_capable: assert property (
		rd_done && paddr_i == OFS_HW_MODE |-> (prdata_o & ~{6'h00, HW_CAPABLE}) == 32'h00000000)
		else $error("hardware mode on an incapable counter");
endmodule
bind pulse_counter_bank pulse_counter_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.fast_input_points_i(fast_input_points_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o));

/* File: test/pulse_source.sv */
// pulse source and two-phase encoder model on the fast input points.
// assumes one caller process at a time uses its tasks.
`timescale 1ns/1ps
module pulse_source
(
	input wire logic sys_clk_i,
	output logic [7:0] pins_o
);
	// each level stands HOLD+1 clocks, a scaled stand-in for the rate limits
	localparam int HOLD = 4;
	initial pins_o = 8'h00;
	// ==========================================================
	// one pin, one function per test sequence
	task automatic level(input int n, input logic v);
		@(posedge sys_clk_i);
		pins_o[n] <= v;
		repeat (HOLD) @(posedge sys_clk_i);
	endtask
	task automatic pulse(input int n, input int cnt);
		repeat (cnt)
		begin
			level(n, 1'b1);
			level(n, 1'b0);
		end
	endtask
	// phase a on pin a, phase b on pin a+1; a leads b when fwd is set
	task automatic quad(input int a, input int cyc, input logic fwd);
		logic [1:0] ph;
		ph = 2'h0;
		repeat (4 * cyc)
		begin
			ph = fwd ? ph + 2'h1 : ph - 2'h1;
			@(posedge sys_clk_i);
			pins_o[a] <= ph[1] ^ ph[0];
			pins_o[a + 1] <= ph[1];
			repeat (HOLD) @(posedge sys_clk_i);
		end
	endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the pulse counter bank over apb.
// assumes the pulse source model drives all eight fast inputs.
`timescale 1ns/1ps
module tb_top
	import pulse_counter_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000;
	wire logic [7:0] fast_input_points_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic [31:0] rdata;
	logic rerr;
	int fails = 0;
	int compares = 0;
	always #2 sys_clk_i = ~sys_clk_i;
	pulse_source src (.sys_clk_i(sys_clk_i), .pins_o(fast_input_points_i));
	pulse_counter_bank DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.fast_input_points_i(fast_input_points_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o));
	// ==========================================================
	// verdict and comparison
	task automatic summarize();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ==========================================================
	// apb transfer: request held until pready_o is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1)
		begin
			fails++;
			summarize();
		end
		rdata = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'b0, a, 32'h00000000);
		chk(rdata & m, exp);
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++)
			rd(12'(4 * i), 32'h00000000, '1);
		rd(OFS_COUNT_BASE, 32'h00000000, '1);
		wr_all: begin end
		apb(1'b1, OFS_ENABLE, 32'h03FFFFFF);
		apb(1'b1, OFS_SW_REF, 32'h00000003);
		rd(OFS_HW_MODE, 32'h00041000, '1);
		// single input: rising edges only, start pin gates counter 8
		src.pulse(0, 3);
		rd(OFS_COUNT_BASE, 32'h00000003, '1);
		rd(OFS_COUNT_BASE + 12'h020, 32'h00000000, '1);
		apb(1'b1, OFS_DIR_SEL, 32'h00000001);
		src.level(6, 1'b1);
		src.pulse(0, 1);
		rd(OFS_COUNT_BASE, 32'h00000002, '1);
		rd(OFS_COUNT_BASE + 12'h020, 32'h00000001, '1);
		src.level(6, 1'b0);
		// up/down pins, with the reset pin of counter 13 held high
		apb(1'b1, OFS_COUNT_BASE + 12'h030, 32'h00000000);
		src.level(2, 1'b1);
		src.pulse(0, 2);
		src.pulse(1, 1);
		rd(OFS_COUNT_BASE + 12'h030, 32'h00000001, '1);
		rd(OFS_DIR_MON, 32'h00000001, 32'h00000001);
		rd(OFS_COUNT_BASE + 12'h034, 32'h00000000, '1);
		rd(OFS_PINS, 32'h00000004, '1);
		src.level(2, 1'b0);
		// quadrature single rate across the 32-bit wrap
		apb(1'b1, OFS_COUNT_BASE + 12'h048, 32'hFFFFFFFE);
		src.quad(0, 2, 1'b1);
		rd(OFS_COUNT_BASE + 12'h048, 32'h00000000, '1);
		rd(OFS_DIR_MON, 32'h00000000, 32'h00000040);
		src.quad(0, 1, 1'b0);
		rd(OFS_COUNT_BASE + 12'h048, 32'hFFFFFFFF, '1);
		rd(OFS_DIR_MON, 32'h00000040, 32'h00000040);
		// fourfold on shared bit 0; counter 20 on bit 2 stays single rate
		apb(1'b1, OFS_FOURFOLD, 32'h00000001);
		apb(1'b1, OFS_COUNT_BASE + 12'h04C, 32'h00000000);
		apb(1'b1, OFS_COUNT_BASE + 12'h050, 32'h00000000);
		src.quad(0, 1, 1'b1);
		rd(OFS_COUNT_BASE + 12'h048, 32'h00000003, '1);
		rd(OFS_COUNT_BASE + 12'h04C, 32'h00000004, '1);
		rd(OFS_DIR_MON, 32'h00000000, 32'h000000C0);
		src.quad(3, 1, 1'b1);
		rd(OFS_COUNT_BASE + 12'h050, 32'h00000001, '1);
		// fourfold backwards: one step down on each edge of both phases, four per cycle
		src.quad(0, 1, 1'b0);
		rd(OFS_COUNT_BASE + 12'h048, 32'hFFFFFFFF, '1);
		rd(OFS_DIR_MON, 32'h00000040, 32'h00000040);
		// status words ignore writes without an error
		apb(1'b1, OFS_HW_MODE, 32'hFFFFFFFF);
		chk({31'h0, rerr}, 32'h00000000);
		rd(OFS_HW_MODE, 32'h00041000, '1);
		// refused places: a hole in the map and the third word past the counts
		apb(1'b0, 12'h020, 32'h00000000);
		chk(rdata, 32'h00000000);
		chk({31'h0, rerr}, 32'h00000001);
		apb(1'b1, 12'h0B0, 32'h00000005);
		chk({31'h0, rerr}, 32'h00000001);
		// an unaligned count place is refused and loads nothing
		apb(1'b1, OFS_COUNT_BASE + 12'h049, 32'h00000055);
		chk({31'h0, rerr}, 32'h00000001);
		rd(OFS_COUNT_BASE + 12'h048, 32'hFFFFFFFF, '1);
		summarize();
	end
endmodule
